// ---- hw/bat_consts.svh ----
// constants of the biphase audio transmitter: offsets, fields, resets
// and clock ratios; included by the transmitter and the bench, definitions only
`ifndef BAT_CONSTS_SVH
`define BAT_CONSTS_SVH

// register offsets on the peripheral port
`define BAT_OFS_CTRL     3'h0
`define BAT_OFS_NONAUDIO 3'h1
`define BAT_OFS_AUDIO_A  3'h2
`define BAT_OFS_AUDIO_B  3'h3
`define BAT_OFS_STATUS   3'h4

// transmit_control fields
`define BAT_EMPTY_IRQ_EN    0
`define BAT_UNDERRUN_IRQ_EN 1
`define BAT_BLOCK_IRQ_EN    2
`define BAT_CLK_SEL         4:3
`define BAT_FORCE_BLOCK     5
`define BAT_CTRL_RST        6'h00

// transmit_status fields
`define BAT_ST_EMPTY    0
`define BAT_ST_UNDERRUN 1
`define BAT_ST_BLOCK    2

// nonaudio_port field, order {cb,ub,vb,ca,ua,va}
`define BAT_NONAUDIO_FIELD 15:10

// preambles, already biphase coded, sent msb first
`define BAT_PRE_X 8'h1D
`define BAT_PRE_Y 8'h1B
`define BAT_PRE_Z 8'h17

// framing
`define BAT_LAST_FRAME 8'hBF
`define BAT_SLOT_DATA  5'h04
`define BAT_SLOT_PAR   5'h1F

// clock ratios against the sample rate
`define BAT_RATIO_CORE    1024
`define BAT_RATIO_EXT_LO  256
`define BAT_RATIO_EXT_MID 384
`define BAT_RATIO_EXT_HI  512
`define BAT_RATIO_BIPHASE 128

`endif

// ---- hw/bat_pkg.sv ----
// types of the biphase audio transmitter
// assumes the constants header is compiled alongside
package bat_pkg;

	// state of the two-entry audio buffer
	typedef struct packed {
		logic [23:0] w0;
		logic [23:0] w1;
		logic [1:0]  cnt;
	} bat_buf_s;

	// state of the transmitter
	typedef struct packed {
		logic        ext_s1;
		logic        ext_s2;
		logic        ext_s3;
		logic [5:0]  transmit_control;
		logic [5:0]  nonaudio_port;
		logic        audio_empty_flag;
		logic        underrun_flag;
		logic        block_end_flag;
		logic [1:0]  clr_arm;
		logic        wr_sel;
		logic [2:0]  div_cnt;
		logic        chan_b;
		logic [4:0]  slot;
		logic        half;
		logic [7:0]  frame;
		logic [7:0]  preamble;
		logic [26:0] subframe_shifter;
		logic        parity;
		logic        line;
		logic        replay;
		logic [2:0]  nonaudio_b_holder;
		logic [23:0] last_a;
		logic [23:0] last_b;
		logic [23:0] rdata;
	} bat_state_s;

endpackage

// ---- hw/bat_pair_buf.sv ----
// two-entry audio buffer: channel a and channel b words in write order
// assumes one clock, async active-low reset, flush from same domain
`timescale 1ns/1ps
`default_nettype none

module bat_pair_buf
	import bat_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	input  wire logic        flush,
	input  wire logic        in_valid,
	input  wire logic [23:0] in_data,
	output logic             in_ready,
	output logic             out_valid,
	output logic [23:0]      out_data,
	input  wire logic        out_ready
);

	bat_buf_s q;
	bat_buf_s d;

	// handshakes from the fill level, head word from flops
	assign in_ready  = (q.cnt != 2'h2);
	assign out_valid = (q.cnt != 2'h0);
	assign out_data  = q.w0;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// pop shifts the tail forward, push fills the first free entry
	always_comb
	begin
		logic       pop;
		logic       push;
		logic [1:0] wi;
		d    = q;
		pop  = out_valid & out_ready;
		push = in_valid & in_ready;
		wi   = q.cnt - 2'(pop);
		if (clk_en)
		begin
			if (flush)
				d.cnt = 2'h0;
			else
			begin
				if (pop)
					d.w0 = q.w1;
				if (push && wi == 2'h0)
					d.w0 = in_data;
				if (push && wi == 2'h1)
					d.w1 = in_data;
				d.cnt = q.cnt + 2'(push) - 2'(pop);
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			q <= '0;
		else
			q <= d;
	end

endmodule // bat_pair_buf

`default_nettype wire

// ---- hw/bat_transmitter.sv ----
// biphase audio transmitter: status flags, parity, biphase encoder,
// preamble generator, frame/block sequencer and clock divider
// assumes the core drives the register port on sys_clk; the external
// clock pin is asynchronous and is synchronised here
//
// Behaviour
// RL1: 24-bit read-only status, cleared on hardware, soft and stop reset; personal reset with both pin functions off keeps the flags
// RL2: audio-empty set when channel a enters shifter
// RL3: empty interrupt while flag and enable set
// RL4: two written words clear audio-empty
// RL5: underrun set when upload finds buffer empty
// RL6: underrun replays previous frame in both channels
// RL7: underrun interrupt while flag and enable set
// RL8: underrun clears after flagged read, two writes
// RL9: block-end set entering frame 191
// RL10: block-end only swaps empty vector for block
// RL11: two written words clear block-end
// RL12: status bits 3 to 23 read zero
// RL13: parity makes slots 4 to 31 even
// RL14: biphase mark encoding on output pin
// RL15: preambles x, y, z loaded per subframe
// RL16: z first, then y, x/y for 192 frames
// RL17: biphase 128fs, shift 64fs from selected source
// RL18: core clock at least five times shift clock
// RL19: software enables only after data and control
// RL20: software keeps empty enable low under dma
// RL21: dma request while port and buffer empty
// RL22: stop holds reset, flags cleared, control kept
// RL23: audio writes alternate channel a, channel b
// RL24: validity, user, status in slots 28-30
// RL25: clock select picks core or pin ratio
// RL26: force block start restarts, then self-clears
// RL27: frame is two 32-slot subframes
`timescale 1ns/1ps
`default_nettype none

`include "bat_consts.svh"

module bat_transmitter
	import bat_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	input  wire logic        soft_rst,
	input  wire logic        stop_mode,
	input  wire logic        output_pin_function,
	input  wire logic        clock_pin_function,
	input  wire logic        external_clock_pin,
	input  wire logic [2:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [23:0] reg_wdata,
	output logic [23:0]      reg_rdata,
	output logic             audio_ready,
	output logic             dma_req,
	output logic             empty_irq_req,
	output logic             underrun_irq_req,
	output logic             block_irq_req,
	output logic             biphase_output_pin
);

	localparam bat_state_s ST_RST = '{frame: `BAT_LAST_FRAME, default: '0};

	bat_state_s q;
	bat_state_s d;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// source events per biphase half-bit for a clock select code
	function automatic logic [2:0] half_div(input logic [1:0] cs);
		unique case (cs)
			2'h0: half_div = 3'(`BAT_RATIO_CORE / `BAT_RATIO_BIPHASE);
			2'h1: half_div = 3'(`BAT_RATIO_EXT_LO / `BAT_RATIO_BIPHASE);
			2'h2: half_div = 3'(`BAT_RATIO_EXT_MID / `BAT_RATIO_BIPHASE);
			2'h3: half_div = 3'(`BAT_RATIO_EXT_HI / `BAT_RATIO_BIPHASE);
		endcase
	endfunction

	// ---------------------------------------------------------------
	// events of the current cycle
	// ---------------------------------------------------------------
	logic        running;
	logic        reinit;
	logic        src_evt;
	logic        tick;
	logic        a_up;
	logic        b_up;
	logic        aud_wr;
	logic        buf_ready;
	logic        buf_valid;
	logic [23:0] buf_data;
	logic        buf_pop;
	logic [2:0]  div;

	// both pin functions off puts the transmitter in personal reset
	assign running = output_pin_function | clock_pin_function;
	assign reinit  = soft_rst | stop_mode; // [RL22]
	assign div     = half_div(q.transmit_control[`BAT_CLK_SEL]); // [RL25]
	// rising edge of the synchronised pin, or every core cycle
	assign src_evt = (q.transmit_control[`BAT_CLK_SEL] == 2'h0) ?
		1'b1 : (q.ext_s2 & ~q.ext_s3);
	// one tick per biphase half-bit, two per shift slot
	assign tick = running & ~reinit & src_evt
		& (q.div_cnt == div - 3'h1); // [RL17]
	assign a_up = tick & ~q.chan_b & (q.slot == 5'h00) & ~q.half;
	assign b_up = tick & q.chan_b & (q.slot == 5'h00) & ~q.half;
	assign aud_wr = reg_wr & ((reg_addr == `BAT_OFS_AUDIO_A)
		| (reg_addr == `BAT_OFS_AUDIO_B));
	// channel a pops only when both words wait; b pops unless replaying
	assign buf_pop = (a_up & ~buf_ready) | (b_up & ~q.replay);

	// ---------------------------------------------------------------
	// audio buffer between write port and shifter
	// ---------------------------------------------------------------
	// successive writes land in a then b order
	bat_pair_buf u_buf (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.clk_en    (clk_en),
		.flush     (reinit),
		.in_valid  (aud_wr & ~reinit),
		.in_data   (reg_wdata),
		.in_ready  (buf_ready),
		.out_valid (buf_valid),
		.out_data  (buf_data),
		.out_ready (buf_pop)
	); // [RL23]

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign reg_rdata          = q.rdata;
	assign audio_ready        = buf_ready;
	assign biphase_output_pin = q.line;
	assign dma_req            = q.audio_empty_flag; // [RL21]
	// block-end only redirects the empty request
	assign block_irq_req = q.audio_empty_flag & q.block_end_flag
		& q.transmit_control[`BAT_BLOCK_IRQ_EN]; // [RL10]
	assign empty_irq_req = q.audio_empty_flag
		& q.transmit_control[`BAT_EMPTY_IRQ_EN] & ~block_irq_req; // [RL3]
	assign underrun_irq_req = q.underrun_flag
		& q.transmit_control[`BAT_UNDERRUN_IRQ_EN]; // [RL7]

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic [7:0] fnum;
		logic [2:0] pidx;
		logic       bitv;
		d    = q;
		fnum = 8'h00;
		pidx = 3'h0;
		bitv = 1'b0;
		if (clk_en)
		begin
			// pin synchroniser; the second and third stages feed the edge detect
			d.ext_s1 = external_clock_pin;
			d.ext_s2 = q.ext_s1;
			d.ext_s3 = q.ext_s2;

			// register reads, status bits above 2 read as zero
			if (reg_rd)
			begin
				unique case (reg_addr)
					`BAT_OFS_CTRL:
						d.rdata = {18'h0_0000, q.transmit_control};
					`BAT_OFS_STATUS:
						d.rdata = {21'h00_0000, q.block_end_flag,
							q.underrun_flag, q.audio_empty_flag}; // [RL12]
					default:
						d.rdata = 24'h00_0000;
				endcase
				// a read that shows underrun arms its clear
				if (reg_addr == `BAT_OFS_STATUS && q.underrun_flag
					&& q.clr_arm == 2'h0)
					d.clr_arm = 2'h1; // [RL8]
			end

			// audio writes: the b word completes the pair
			if (aud_wr && buf_ready)
			begin
				d.wr_sel = ~q.wr_sel;
				if (q.wr_sel)
				begin
					d.audio_empty_flag = 1'b0; // [RL4]
					d.block_end_flag   = 1'b0; // [RL11]
				end
				if (q.clr_arm == 2'h1)
					d.clr_arm = 2'h2;
				else if (q.clr_arm == 2'h2)
				begin
					d.clr_arm       = 2'h0;
					d.underrun_flag = 1'b0; // [RL8]
				end
			end
			if (reg_wr && reg_addr == `BAT_OFS_NONAUDIO)
				d.nonaudio_port = reg_wdata[`BAT_NONAUDIO_FIELD];

			// half-bit divider on the selected source
			if (src_evt)
				d.div_cnt = (q.div_cnt == div - 3'h1) ? 3'h0
					: q.div_cnt + 3'h1; // [RL17]

			// channel a upload starts the frame
			if (a_up)
			begin
				fnum = (q.frame == `BAT_LAST_FRAME
					|| q.transmit_control[`BAT_FORCE_BLOCK]) ? 8'h00
					: q.frame + 8'h01; // [RL16]
				d.frame = fnum;
				d.transmit_control[`BAT_FORCE_BLOCK] = 1'b0; // [RL26]
				d.preamble = (fnum == 8'h00) ? `BAT_PRE_Z
					: `BAT_PRE_X; // [RL15]
				d.audio_empty_flag = 1'b1; // [RL2]
				if (fnum == `BAT_LAST_FRAME)
					d.block_end_flag = 1'b1; // [RL9]
				d.nonaudio_b_holder = q.nonaudio_port[5:3];
				d.parity = 1'b0;
				if (!buf_ready)
				begin
					d.subframe_shifter = {q.nonaudio_port[2:0], buf_data};
					d.last_a = buf_data;
					d.replay = 1'b0;
				end
				else
				begin
					// missing pair: repeat last frame in both channels
					d.underrun_flag    = 1'b1; // [RL5]
					d.replay           = 1'b1; // [RL6]
					d.subframe_shifter = {q.nonaudio_port[2:0], q.last_a};
				end
			end

			// channel b upload
			if (b_up)
			begin
				d.preamble = `BAT_PRE_Y; // [RL15]
				d.parity   = 1'b0;
				if (!q.replay && buf_valid)
				begin
					d.subframe_shifter = {q.nonaudio_b_holder, buf_data};
					d.last_b = buf_data;
				end
				else
				begin
					if (!q.replay)
						d.underrun_flag = 1'b1; // [RL5]
					// slots 28 to 30 carry v, u, c
					d.subframe_shifter = {q.nonaudio_b_holder,
						q.last_b}; // [RL24]
				end
			end

			// line coding, one half-bit per tick
			if (tick)
			begin
				if (q.slot < `BAT_SLOT_DATA)
				begin
					pidx   = {q.slot[1:0], q.half};
					d.line = d.preamble[3'h7 - pidx]; // [RL15]
				end
				else
				begin
					bitv = (q.slot == `BAT_SLOT_PAR) ? q.parity
						: q.subframe_shifter[0]; // [RL13]
					if (!q.half)
						d.line = ~q.line; // [RL14]
					else
					begin
						if (bitv)
							d.line = ~q.line; // [RL14]
						if (q.slot != `BAT_SLOT_PAR)
						begin
							d.subframe_shifter = q.subframe_shifter >> 1;
							d.parity = q.parity ^ bitv; // [RL13]
						end
					end
				end
				// advance slot position within the frame
				d.half = ~q.half;
				if (q.half)
				begin
					d.slot = q.slot + 5'h01; // [RL27]
					if (q.slot == `BAT_SLOT_PAR)
						d.chan_b = ~q.chan_b; // [RL27]
				end
			end

			// control write last so a software set beats the clear
			if (reg_wr && reg_addr == `BAT_OFS_CTRL)
				d.transmit_control = reg_wdata[5:0];

			// personal reset while disabled: sequence restarts at z
			if (!running || reinit)
			begin
				d.div_cnt = 3'h0;
				d.chan_b  = 1'b0;
				d.slot    = 5'h00;
				d.half    = 1'b0;
				d.frame   = `BAT_LAST_FRAME; // [RL16]
				d.line    = 1'b0;
				d.replay  = 1'b0;
			end
			// soft reset and stop clear status; only soft clears control
			if (reinit)
			begin
				d.audio_empty_flag = 1'b0; // [RL1]
				d.underrun_flag    = 1'b0; // [RL1]
				d.block_end_flag   = 1'b0; // [RL1]
				d.clr_arm          = 2'h0;
				d.wr_sel           = 1'b0;
				if (soft_rst)
					d.transmit_control = `BAT_CTRL_RST;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			q <= ST_RST;
		else
			q <= d;
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst || soft_rst || stop_mode);

	status_reserved_a: assert property ( // [RL12]
		$past(reg_rd) && $past(reg_addr) == `BAT_OFS_STATUS
		|-> reg_rdata[23:3] == 21'h00_0000)
		else $error("status reserved bits not zero");

	empty_set_a: assert property ( // [RL2]
		a_up && clk_en |=> q.audio_empty_flag && q.slot == 5'h00)
		else $error("audio empty not set at frame start");

	empty_irq_a: assert property ( // [RL3]
		q.audio_empty_flag && q.transmit_control[0]
		&& !(q.block_end_flag && q.transmit_control[2])
		|-> empty_irq_req && !block_irq_req)
		else $error("empty request missing");

	underrun_set_a: assert property ( // [RL5]
		a_up && clk_en && buf_ready |=> q.underrun_flag && q.replay)
		else $error("underrun not flagged");

	underrun_irq_a: assert property ( // [RL7]
		q.underrun_flag && q.transmit_control[1] |-> underrun_irq_req)
		else $error("underrun request missing");

	block_vector_a: assert property ( // [RL10]
		block_irq_req |-> q.block_end_flag && !empty_irq_req)
		else $error("block request without block end");

	preamble_z_a: assert property ( // [RL16]
		a_up && clk_en && q.frame == `BAT_LAST_FRAME
		|=> q.preamble == `BAT_PRE_Z && q.frame == 8'h00)
		else $error("block did not start with z");

	cell_edge_a: assert property ( // [RL14]
		tick && clk_en && running && q.slot >= `BAT_SLOT_DATA && !q.half
		|=> q.line != $past(q.line))
		else $error("no transition at bit cell start");

	force_clear_a: assert property ( // [RL26]
		a_up && clk_en && q.transmit_control[5]
		&& !(reg_wr && reg_addr == `BAT_OFS_CTRL)
		|=> !q.transmit_control[5] && q.frame == 8'h00)
		else $error("force block start not honoured");

endmodule // bat_transmitter

`default_nettype wire

// ---- test/bat_rx_model.sv ----
// receiver model of the biphase line: recovers half-bits, finds a
// preamble and decodes the subframe that starts with it
// assumes the line is sampled on sys_clk and half_len is even
`timescale 1ns/1ps
`default_nettype none

module bat_rx_model
(
	input  wire logic        sys_clk,
	input  wire logic        line,
	input  wire logic [3:0]  half_len,
	output logic             sub_stb,
	output logic [7:0]       sub_pre,
	output logic [27:0]      sub_bits,
	output logic             sub_bad
);
	logic        prev = 1'b0;
	logic [3:0]  cnt  = 4'h0;
	logic [63:0] hb   = 64'h0;
	logic [63:0] nx;
	logic [7:0]  pre;
	integer      i;

	// ------------------------------------------------------------
	// half-bit recovery, resynchronised on every line edge
	// ------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		prev    <= line;
		sub_stb <= 1'b0;
		cnt     <= (line != prev || cnt == half_len) ? 4'h1 : cnt + 4'h1;
		if (cnt == half_len / 4'h2)
		begin
			nx  = {hb[62:0], line};
			hb  <= nx;
			pre = nx[63] ? ~nx[63:56] : nx[63:56]; // either polarity
			if (pre == 8'h1D || pre == 8'h1B || pre == 8'h17)
			begin
				sub_stb <= 1'b1;
				sub_pre <= pre;
				sub_bad <= 1'b0;
				// a data cell must toggle at its start
				for (i = 0; i < 28; i++)
				begin
					sub_bits[i] <= nx[55 - 2 * i] ^ nx[54 - 2 * i];
					if (nx[55 - 2 * i] == nx[56 - 2 * i])
						sub_bad <= 1'b1;
				end
			end
		end
	end
endmodule // bat_rx_model

`default_nettype wire

// ---- test/biphase_audio_transmitter_bench.sv ----
// self-checking bench: register tasks drive the transmitter, the
// receiver model decodes the line; runs core clock then pin clock
// assumes the design and its constants header are compiled first
`timescale 1ns/1ps
`default_nettype none

`include "bat_consts.svh"

module biphase_audio_transmitter_bench;
	logic        sys_clk   = 1'b0;
	logic        nrst      = 1'b0;
	logic        soft_rst  = 1'b0;
	logic        stop_mode = 1'b0;
	logic        out_fn    = 1'b0;
	logic        clk_fn    = 1'b0;
	logic        ext_pin   = 1'b0;
	logic [2:0]  reg_addr  = 3'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [23:0] reg_wdata = 24'h00_0000;
	logic [3:0]  half_len  = 4'h8;
	logic [23:0] reg_rdata;
	logic        audio_ready, dma_req, line;
	logic        empty_irq_req, underrun_irq_req, block_irq_req;
	logic        sub_stb, sub_bad;
	logic [7:0]  sub_pre, p;
	logic [27:0] sub_bits, b;
	int          failures = 0;
	int          n_checks = 0;
	int          cyc      = 0;
	int          f, k;

	bat_transmitter u_bat_transmitter (.sys_clk(sys_clk), .nrst(nrst),
		.clk_en(1'b1), .soft_rst(soft_rst), .stop_mode(stop_mode),
		.output_pin_function(out_fn), .clock_pin_function(clk_fn),
		.external_clock_pin(ext_pin), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .audio_ready(audio_ready),
		.dma_req(dma_req), .empty_irq_req(empty_irq_req),
		.underrun_irq_req(underrun_irq_req),
		.block_irq_req(block_irq_req), .biphase_output_pin(line));

	bat_rx_model u_bat_rx_model (.sys_clk(sys_clk), .line(line),
		.half_len(half_len), .sub_stb(sub_stb), .sub_pre(sub_pre),
		.sub_bits(sub_bits), .sub_bad(sub_bad));

	// ------------------------------------------------------------
	// clock, external pin clock, watchdog
	// ------------------------------------------------------------
	initial
	begin
		forever #10 sys_clk = ~sys_clk;
	end

	// pin clock at half the core rate, a tick every 4 cycles at code 01
	always @(posedge sys_clk)
	begin
		ext_pin <= ~ext_pin;
		cyc     <= cyc + 1;
		if (cyc == 120000)
		begin
			failures++;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input logic [27:0] seen, input logic [27:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [23:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
		@(posedge sys_clk);
	endtask

	// audio words go to one offset; the design alternates a and b
	task automatic wa(input logic [23:0] d);
		while (audio_ready !== 1'b1)
			@(posedge sys_clk);
		wr(`BAT_OFS_AUDIO_A, d);
	endtask

	task automatic rdc(input logic [2:0] a, input logic [23:0] e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		@(posedge sys_clk);
		check(reg_rdata, e);
	endtask

	// next decoded subframe from the receiver model
	task automatic sub();
		@(posedge sys_clk);
		while (sub_stb !== 1'b1)
			@(posedge sys_clk);
		p = sub_pre;
		b = sub_bits;
		check(sub_bad, 1'b0);
	endtask

	// slots 4..31: audio lsb first, v, u, c, even parity
	function automatic logic [27:0] ex(input logic [23:0] a,
		input logic [2:0] n);
		ex = {^{n, a}, n, a};
	endfunction

	task automatic finish_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		rdc(`BAT_OFS_STATUS, 24'h00_0000);
		rdc(3'h5, 24'h00_0000);
		wr(`BAT_OFS_NONAUDIO, 24'h00_A400);
		wa(24'h11_1100);
		wa(24'h22_2200);
		check(audio_ready, 1'b0);
		wr(`BAT_OFS_CTRL, 24'h00_0007);
		out_fn <= 1'b1;
		// four frames on the core clock, last one left unfed
		for (f = 0; f < 4; f++)
		begin
			sub();
			check(p, (f == 0) ? 8'h17 : 8'h1D);
			check(b, ex(24'h11_1100 + 24'(f), 3'b001));
			rdc(`BAT_OFS_STATUS, 24'h00_0001);
			check(empty_irq_req, 1'b1);
			check(dma_req, 1'b1);
			if (f < 3)
			begin
				wa(24'h11_1100 + 24'(f + 1));
				wa(24'h22_2200 + 24'(f + 1));
				rdc(`BAT_OFS_STATUS, 24'h00_0000);
			end
			sub();
			check(p, 8'h1B);
			check(b, ex(24'h22_2200 + 24'(f), 3'b101));
		end
		// frame 4 finds the buffer empty and replays frame 3
		sub();
		check(b, ex(24'h11_1103, 3'b001));
		check(underrun_irq_req, 1'b1);
		wa(24'h11_1105);
		wa(24'h22_2205);
		check(underrun_irq_req, 1'b1);
		sub();
		check(b, ex(24'h22_2203, 3'b101));
		rdc(`BAT_OFS_STATUS, 24'h00_0002);
		wa(24'h11_1106);
		wa(24'h22_2206);
		rdc(`BAT_OFS_STATUS, 24'h00_0000);
		wr(`BAT_OFS_CTRL, 24'h00_0027);
		sub();
		sub();
		check(p, 8'h17);
		check(b, ex(24'h11_1106, 3'b001));
		rdc(`BAT_OFS_CTRL, 24'h00_0007);
		// stop keeps control, clears status; soft reset clears both
		stop_mode <= 1'b1;
		@(posedge sys_clk);
		rdc(`BAT_OFS_STATUS, 24'h00_0000);
		rdc(`BAT_OFS_CTRL, 24'h00_0007);
		stop_mode <= 1'b0;
		out_fn    <= 1'b0;
		soft_rst  <= 1'b1;
		@(posedge sys_clk);
		soft_rst  <= 1'b0;
		@(posedge sys_clk);
		rdc(`BAT_OFS_CTRL, 24'h00_0000);
		// a whole block on the pin clock at code 01
		half_len <= 4'h4;
		wa(24'h33_0000);
		wa(24'h44_0000);
		wr(`BAT_OFS_CTRL, 24'h00_000D);
		clk_fn <= 1'b1;
		out_fn <= 1'b1;
		for (k = 0; k < 192; k++)
		begin
			while (dma_req !== 1'b1)
				@(posedge sys_clk);
			if (k > 188)
			begin
				check(block_irq_req, k == 191);
				check(empty_irq_req, k != 191);
				rdc(`BAT_OFS_STATUS, {21'h0, k == 191, 2'b01});
			end
			wa(24'h33_0000 + 24'(k + 1));
			wa(24'h44_0000 + 24'(k + 1));
		end
		rdc(`BAT_OFS_STATUS, 24'h00_0000);
		// served as by dma from here: empty interrupt kept off
		wr(`BAT_OFS_CTRL, 24'h00_000C);
		sub();
		sub();
		check(p, 8'h17);
		check(b, ex(24'h33_00C0, 3'b001));
		check(empty_irq_req, 1'b0);
		check(dma_req, 1'b1);
		finish_test();
	end
endmodule // biphase_audio_transmitter_bench

`default_nettype wire
